// *** rtl/seaa_top.v ***
// Serial memory-array access logic: read, page write, status polling.
// Assumes serial pins arrive asynchronously and are sampled by clk_i at
// 40 MHz; the serial clock must be well below a quarter of that rate.
// TWC_CYCLES must be at least 32 so that the page buffer drains in full
// before the programming count runs out.
`timescale 1ns/100ps
`include "seaa_consts.vh"

module seaa_top #(
  parameter [23:0] TWC_CYCLES = `SEAA_TWC_CYC // Programming cycle length.
) (
  input  wire       clk_i,            // System clock, 40 MHz.
  input  wire       sys_rst_i,        // Synchronous reset, active high.
  input  wire       cs_n_i,           // Chip select pin, active low.
  input  wire       sck_i,            // Serial clock pin.
  input  wire       si_i,             // Serial data input pin.
  input  wire       block_protect_lo, // Protect level bit 0 (level input).
  input  wire       block_protect_hi, // Protect level bit 1 (level input).
  output reg        so_o,             // Serial data output value.
  output reg        so_oe_o,          // Serial output enable, high drives.
  output reg        busy_o,           // Programming cycle running.
  output reg        wel_o             // Write-enable latch state.
);

  // ----------------------------------------------------------------
  // Local states
  // ----------------------------------------------------------------
  localparam [2:0] ST_CMD    = 3'd0;
  localparam [2:0] ST_ADDR   = 3'd1;
  localparam [2:0] ST_RDATA  = 3'd2;
  localparam [2:0] ST_WDATA  = 3'd3;
  localparam [2:0] ST_STATUS = 3'd4;
  localparam [2:0] ST_IGNORE = 3'd5;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg  [1:0] cs_sync;
  reg  [1:0] sck_sync;
  reg  [1:0] si_sync;
  reg  [1:0] bp_sync_lo;
  reg  [1:0] bp_sync_hi;
  reg        cs_q;
  reg        sck_q;

  // Two flops on every pin; edge detectors compare the second flop with a third flop.
  always @(posedge clk_i) begin
    cs_sync    <= {cs_sync[0], cs_n_i};
    sck_sync   <= {sck_sync[0], sck_i};
    si_sync    <= {si_sync[0], si_i};
    bp_sync_lo <= {bp_sync_lo[0], block_protect_lo};
    bp_sync_hi <= {bp_sync_hi[0], block_protect_hi};
    cs_q       <= cs_sync[1];
    sck_q      <= sck_sync[1];
  end

  wire cs_n     = cs_sync[1];
  wire cs_fall  = cs_q & ~cs_n;
  wire cs_rise  = ~cs_q & cs_n;
  wire sck_rise = ~sck_q & sck_sync[1] & ~cs_n;
  wire sck_fall = sck_q & ~sck_sync[1] & ~cs_n;
  wire si_bit   = si_sync[1];

  // ----------------------------------------------------------------
  // Transaction state
  // ----------------------------------------------------------------
  reg  [2:0]          state;
  reg  [2:0]          bit_cnt;
  reg  [3:0]          addr_cnt;
  reg  [7:0]          shift_in;
  reg  [7:0]          shift_out;
  reg  [`SEAA_AW-1:0] addr;
  reg  [`SEAA_AW-1:0] page_base;
  reg  [31:0]         page_valid;
  reg  [7:0]          page_buf [0:31];
  reg                 wr_pending;
  reg                 byte_done;
  reg                 load_out;
  reg                 load_dly;
  reg  [23:0]         twc_cnt;
  reg  [4:0]          prog_idx;
  reg                 prog_we;
  reg  [`SEAA_AW-1:0] prog_addr;
  reg  [7:0]          prog_data;
  reg                 prot_hit;

  wire [7:0] next_shift_in = {shift_in[6:0], si_bit};
  wire [7:0] mem_rdata;
  wire [4:0] page_off      = addr[`SEAA_PAGE_BITS-1:0];
  wire       op_ok         = (next_shift_in[7:4] == `SEAA_OP_HI);
  wire [2:0] op_lo         = next_shift_in[2:0];

  // Last cycle of the programming count; busy drops on this edge.
  wire       twc_done      = (twc_cnt <= 24'd1);

  // Protected bytes still pass through the drain but never reach the array.
  wire       mem_we        = prog_we & ~prot_hit;

  // Status byte: all ones while busy, else latch and protect bits.
  wire [7:0] status_byte = busy_o ? 8'hff :
    {4'h0, bp_sync_hi[1], bp_sync_lo[1], wel_o, 1'b0};

  // ----------------------------------------------------------------
  // Block protection
  // ----------------------------------------------------------------

  // Protect compare for the address about to be programmed.
  always @* begin
    case ({bp_sync_hi[1], bp_sync_lo[1]})
      2'b01:   prot_hit = (prog_addr >= `SEAA_PROT_L1);
      2'b10:   prot_hit = (prog_addr >= `SEAA_PROT_L2);
      2'b11:   prot_hit = (prog_addr >= `SEAA_PROT_L3);
      default: prot_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Array storage
  // ----------------------------------------------------------------

  // The array; the page buffer drains into it one byte per clock.
  seaa_mem u_mem (
    .clk_i   (clk_i),
    .we_i    (mem_we),
    .waddr_i (prog_addr),
    .wdata_i (prog_data),
    .raddr_i (addr),
    .rdata_o (mem_rdata)
  );

  // ----------------------------------------------------------------
  // Serial command engine
  // ----------------------------------------------------------------
  // Commands are decoded on the eighth rising serial edge. The page is
  // gathered in a local buffer so that an aborted write leaves the array
  // untouched, at the cost of 32 bytes of flops.
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      state      <= ST_IGNORE;
      bit_cnt    <= 3'd0;
      addr_cnt   <= 4'd0;
      shift_in   <= 8'h00;
      shift_out  <= 8'h00;
      addr       <= {`SEAA_AW{1'b0}};
      page_base  <= {`SEAA_AW{1'b0}};
      page_valid <= 32'h00000000;
      wr_pending <= 1'b0;
      byte_done  <= 1'b0;
      load_out   <= 1'b0;
      load_dly   <= 1'b0;
      so_o       <= 1'b0;
      so_oe_o    <= 1'b0;
      wel_o      <= 1'b0;
      busy_o     <= 1'b0;
      twc_cnt    <= 24'h000000;
      prog_idx   <= 5'd0;
      prog_we    <= 1'b0;
      prog_addr  <= {`SEAA_AW{1'b0}};
      prog_data  <= 8'h00;
    end else begin
      prog_we  <= 1'b0;
      load_out <= 1'b0;
      load_dly <= load_out;
      // Every command starts afresh on a chip select falling edge.
      if (cs_fall) begin
        state      <= ST_CMD;
        bit_cnt    <= 3'd0;
        addr_cnt   <= 4'd0;
        byte_done  <= 1'b0;
        wr_pending <= 1'b0;
      end else if (cs_rise) begin
        so_oe_o <= 1'b0;
        state   <= ST_IGNORE;
        // Program only when the last byte ended cleanly.
        if (wr_pending && byte_done && bit_cnt == 3'd0 &&
            page_valid != 32'h00000000) begin
          busy_o   <= 1'b1;
          twc_cnt  <= TWC_CYCLES;
          prog_idx <= 5'd0;
        end else if (!busy_o) begin
          page_valid <= 32'h00000000;
        end
        wr_pending <= 1'b0;
      end else if (sck_rise) begin
        shift_in <= next_shift_in;
        bit_cnt  <= bit_cnt + 3'd1;
        byte_done <= 1'b0;
        if (bit_cnt == 3'd7) begin
          byte_done <= 1'b1;
          case (state)
            ST_CMD: begin
              state <= ST_IGNORE;
              if (op_ok && op_lo == `SEAA_OP_RD_STATUS) begin
                state <= ST_STATUS;
              end else if (op_ok && !busy_o) begin
                case (op_lo)
                  `SEAA_OP_READ: state <= ST_ADDR;
                  `SEAA_OP_WRITE: begin
                    if (wel_o) begin
                      state      <= ST_ADDR;
                      wr_pending <= 1'b1;
                      page_valid <= 32'h00000000;
                    end
                  end
                  `SEAA_OP_SET_WEL: wel_o <= 1'b1;
                  `SEAA_OP_CLR_WEL: wel_o <= 1'b0;
                  default: state <= ST_IGNORE;
                endcase
              end
            end
            ST_ADDR: begin
              addr_cnt <= addr_cnt + 4'd1;
              // Upper four address bits fall off the top.
              addr <= {addr[3:0], next_shift_in};
              if (addr_cnt == 4'd1) begin
                if (wr_pending) begin
                  state     <= ST_WDATA;
                  page_base <= {addr[3:0], next_shift_in};
                end else begin
                  state    <= ST_RDATA;
                  load_out <= 1'b1;
                end
              end
            end
            ST_WDATA: begin
              // Only the in-page offset moves; the page itself stays put.
              page_buf[page_off]   <= next_shift_in;
              page_valid[page_off] <= 1'b1;
              addr[4:0]            <= page_off + 5'd1;
            end
            ST_RDATA: begin
              // The full 12-bit address rolls over from the top to zero.
              addr     <= addr + 12'd1;
              load_out <= 1'b1;
            end
            default: state <= state;
          endcase
        end
      end else if (sck_fall) begin
        // Output moves after the falling edge, MSB first.
        if (state == ST_RDATA || state == ST_STATUS) begin
          so_oe_o   <= 1'b1;
          so_o      <= shift_out[7];
          shift_out <= {shift_out[6:0], 1'b0};
          if (state == ST_STATUS && bit_cnt == 3'd0) begin
            so_o      <= status_byte[7];
            shift_out <= {status_byte[6:0], 1'b0};
          end
        end
      end
      // The address register feeds the array, whose read data is itself
      // registered, so the byte is ready two clocks after the address.
      // The serial clock is slow enough that this lands before its fall.
      if (load_dly) begin
        shift_out <= mem_rdata;
      end
      // --------------------------------------------------------------
      // Programming sequencer
      // --------------------------------------------------------------
      // Drain the buffer, then wait out the cycle counter. The count runs
      // on every clock of the cycle, also while a status poll opens or
      // closes a frame, so busy lasts exactly TWC_CYCLES clocks.
      if (busy_o) begin
        prog_addr <= {page_base[`SEAA_AW-1:`SEAA_PAGE_BITS], prog_idx};
        prog_data <= page_buf[prog_idx];
        prog_we   <= page_valid[prog_idx];
        if (prog_idx != 5'd31) begin
          prog_idx <= prog_idx + 5'd1;
        end
        if (twc_done) begin
          busy_o     <= 1'b0;
          wel_o      <= 1'b0;
          page_valid <= 32'h00000000;
        end else begin
          twc_cnt <= twc_cnt - 24'd1;
        end
      end
    end
  end

endmodule // seaa_top

// *** rtl/seaa_consts.vh ***
// Constants for the serial memory-array access block.
// Assumes inclusion by bare name from the rtl files; definitions only.
`ifndef SEAA_CONSTS_VH
`define SEAA_CONSTS_VH

// Opcode match: upper nibble zero, bit 3 ignored, low three bits compared.
`define SEAA_OP_HI         4'h0
`define SEAA_OP_READ       3'h3
`define SEAA_OP_WRITE      3'h2
`define SEAA_OP_SET_WEL    3'h6
`define SEAA_OP_CLR_WEL    3'h4
`define SEAA_OP_RD_STATUS  3'h5

// Array geometry.
`define SEAA_AW            12
`define SEAA_DEPTH         4096
`define SEAA_PAGE_BITS     5

// Block-protect lower bounds for levels 1, 2 and 3.
`define SEAA_PROT_L1       12'hc00
`define SEAA_PROT_L2       12'h800
`define SEAA_PROT_L3       12'h000

// Status bit positions.
`define SEAA_ST_BUSY       0
`define SEAA_ST_WEL        1
`define SEAA_ST_BP_LO      2
`define SEAA_ST_BP_HI      3

// Self-timed programming cycle: time in microseconds and clock rate.
`define SEAA_TWC_US        5000
`define SEAA_CLK_MHZ       40
// The product of the two above, sized to match the 24-bit cycle counter.
`define SEAA_TWC_CYC       24'd200000

`endif

// *** rtl/seaa_mem.v ***
// Byte-wide array storage for the access block, with registered read.
// Assumes a single clock; write and read may occur in the same cycle.
`timescale 1ns/100ps
`include "seaa_consts.vh"

module seaa_mem (
  input  wire                   clk_i,   // System clock.
  input  wire                   we_i,    // Write strobe.
  input  wire [`SEAA_AW-1:0]    waddr_i, // Write address.
  input  wire [7:0]             wdata_i, // Write data.
  input  wire [`SEAA_AW-1:0]    raddr_i, // Read address.
  output reg  [7:0]             rdata_o  // Registered read data.
);

  reg [7:0] mem [0:`SEAA_DEPTH-1];

  // ----------------------------------------------------------------
  // Storage port
  // ----------------------------------------------------------------
  // Read data is registered so the array maps onto block memory.
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end

endmodule // seaa_mem

// *** tb/seaa_master.sv ***
// Serial master model, mode 0, 200 ns serial clock, for the access block.
// Assumes a 40 MHz bench clock; the bench calls its tasks by hierarchy.
`timescale 1ns/100ps
module seaa_master (
  input  wire clk_i,   // Bench clock.
  input  wire so_i,    // Device serial output.
  input  wire so_oe_i, // Device output enable.
  output reg  cs_n_o,  // Chip select, active low.
  output reg  sck_o,   // Serial clock, stands low outside frames.
  output reg  si_o     // Serial data to the device.
);
  reg  so_last = 1'b0;
  // A released output line shows a changing pattern, never a held value.
  wire so_w = so_oe_i ? so_i : ~so_last;
  always @(posedge clk_i) so_last <= so_w;
  initial begin
    cs_n_o = 1'b1;
    sck_o  = 1'b0;
    si_o   = 1'b0;
  end
  // Each command needs a fresh falling edge of chip select.
  task frame_start;
    begin
      cs_n_o <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask
  // Shift MSB first; drive on the fall, sample at the end of high phase.
  task xfer(input [7:0] tx, input integer nbits, output [7:0] rx);
    integer i;
    begin
      rx = 8'h00;
      for (i = 7; i > 7 - nbits; i = i - 1) begin
        sck_o <= 1'b0;
        si_o  <= tx[i];
        repeat (4) @(posedge clk_i);
        sck_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        rx = {rx[6:0], so_w};
      end
    end
  endtask
  // Chip select rises in the low phase right after the last bit.
  task frame_end;
    begin
      sck_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      cs_n_o <= 1'b1;
      repeat (8) @(posedge clk_i);
    end
  endtask
endmodule // seaa_master

// *** tb/seaa_top_monitor.sv ***
// Concurrent checks on the pins and status outputs of the access block.
// Assumes a bind onto seaa_top, which hands on its programming length.
`timescale 1ns/100ps
module seaa_top_monitor #(
  parameter [23:0] TWC_CYCLES = 24'd200 // Programming cycle length.
) (
  input wire clk_i,            // Clock.
  input wire sys_rst_i,        // Reset.
  input wire cs_n_i,           // Chip select.
  input wire sck_i,            // Serial clock.
  input wire si_i,             // Serial input.
  input wire block_protect_lo, // Protect bit 0.
  input wire block_protect_hi, // Protect bit 1.
  input wire so_o,             // Serial output.
  input wire so_oe_o,          // Output enable.
  input wire busy_o,           // Busy.
  input wire wel_o             // Write latch.
);
  // ----------------------------------------------------------------
  // Programming counter and properties.
  // ----------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  reg [23:0] busy_cnt; // A counter avoids unrolling a long repetition.
  always @(posedge clk_i) busy_cnt <= busy_o ? busy_cnt + 24'd1 : 24'd0;
  sequence deselected; cs_n_i [*6]; endsequence
  sequence prog_launch; cs_n_i ##1 $rose(busy_o); endsequence
  oe_idle_a: assert property (deselected |-> !so_oe_o)
    else $error("output enabled while deselected");
  prog_wel_a: assert property (prog_launch |-> wel_o)
    else $error("programming without write latch");
  busy_cs_a: assert property ($rose(busy_o) |-> cs_n_i)
    else $error("programming began while selected");
  busy_len_a: assert property (
    $fell(busy_o) |-> busy_cnt == TWC_CYCLES)
    else $error("programming length wrong");
  busy_max_a: assert property (busy_o |-> busy_cnt < TWC_CYCLES)
    else $error("busy held too long");
  wel_end_a: assert property ($fell(busy_o) |-> !wel_o)
    else $error("write latch kept after programming");
  wel_hold_a: assert property (
    busy_o && $past(busy_o) |-> $stable(wel_o))
    else $error("write latch changed while busy");
  so_edge_a: assert property (
    so_oe_o && $past(so_oe_o) && $changed(so_o) |-> !$past(sck_i))
    else $error("output changed outside clock low");
endmodule // seaa_top_monitor

// *** tb/seaa_top_test.sv ***
// Self-checking bench for the access block, driven by the master model.
// Assumes the master model and checker files are compiled before it.
`timescale 1ns/100ps
module seaa_top_test;
  // ----------------------------------------------------------------
  // Signals, expected memory, instances.
  // ----------------------------------------------------------------
  reg        clk_i = 1'b0;
  reg        sys_rst_i = 1'b1;
  reg        block_protect_lo = 1'b0;
  reg        block_protect_hi = 1'b0;
  wire       cs_n, sck, si, so, so_oe, busy, wel;
  reg  [7:0] mem [0:4095]; // Expected array content.
  reg  [7:0] rx;
  reg [15:0] a;
  integer    seed = 80605;
  integer    miscompares = 0;
  integer    compares = 0;
  integer    i;
  // Free-running 40 MHz clock.
  always #12.5 clk_i = ~clk_i;
  seaa_top #(.TWC_CYCLES(24'd600)) i_seaa_top (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n), .sck_i(sck),
    .si_i(si), .block_protect_lo(block_protect_lo),
    .block_protect_hi(block_protect_hi), .so_o(so), .so_oe_o(so_oe),
    .busy_o(busy), .wel_o(wel));
  seaa_master i_seaa_master (.clk_i(clk_i), .so_i(so), .so_oe_i(so_oe),
    .cs_n_o(cs_n), .sck_o(sck), .si_o(si));
  function automatic [7:0] rb();
    rb = 8'($random(seed));
  endfunction
  // Protected range for the current level.
  function prot(input [11:0] p);
    case ({block_protect_hi, block_protect_lo})
      2'b01:   prot = p >= 12'hc00;
      2'b10:   prot = p >= 12'h800;
      2'b11:   prot = 1'b1;
      default: prot = 1'b0;
    endcase
  endfunction
  task check(input [47:0] what, input [7:0] seen, input [7:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // Opcode and two address bytes of a new frame.
  task send(input [7:0] op, input [15:0] ad);
    begin
      i_seaa_master.frame_start;
      i_seaa_master.xfer(op, 8, rx);
      i_seaa_master.xfer(ad[15:8], 8, rx);
      i_seaa_master.xfer(ad[7:0], 8, rx);
    end
  endtask
  task cmd(input [7:0] op);
    begin
      i_seaa_master.frame_start;
      i_seaa_master.xfer(op, 8, rx);
      i_seaa_master.frame_end;
    end
  endtask
  task status(input [7:0] exp);
    begin
      send(8'h05, {rb(), rb()});
      i_seaa_master.frame_end;
      check("status", rx, exp);
    end
  endtask
  // Last byte may be cut short; prog says whether programming should run.
  task wr(input [15:0] ad, input integer n, input integer last, input prog);
    integer    k;
    reg [11:0] p;
    reg [7:0]  d;
    begin
      send(8'h02, ad);
      for (k = 0; k < n; k = k + 1) begin
        p = {ad[11:5], ad[4:0] + k[4:0]};
        d = rb();
        if (prog && !prot(p)) mem[p] = d;
        i_seaa_master.xfer(d, (k == n - 1) ? last : 8, rx);
      end
      i_seaa_master.frame_end;
    end
  endtask
  // Serial input carries noise during data, which must be ignored.
  task rd(input [15:0] ad, input integer n);
    integer k;
    begin
      send(8'h03, ad);
      for (k = 0; k < n; k = k + 1) begin
        i_seaa_master.xfer(rb(), 8, rx);
        check("read", rx, mem[ad[11:0] + k[11:0]]);
      end
      i_seaa_master.frame_end;
    end
  endtask
  task idle;
    integer t;
    begin
      for (t = 0; t < 2000 && busy !== 1'b0; t = t + 1) @(posedge clk_i);
      check("busy", {7'h00, busy}, 8'h00);
    end
  endtask
  // Main sequence: refusals, page write under polling, reads, protection.
  initial begin
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    wr(16'h0123, 1, 8, 1'b0);
    check("busy", {7'h00, busy}, 8'h00);
    status(8'h00);
    cmd(8'h0e);
    status(8'h02);
    cmd(8'h04);
    cmd(8'h16);
    status(8'h00);
    cmd(8'h06);
    wr(16'h0040, 2, 4, 1'b0);
    check("busy", {7'h00, busy}, 8'h00);
    wr(16'hffe7, 34, 8, 1'b1);
    check("busy", {7'h00, busy}, 8'h01);
    status(8'hff);
    cmd(8'h04);
    check("wel", {7'h00, wel}, 8'h01);
    idle;
    check("wel", {7'h00, wel}, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      a = (i == 0) ? 16'h0000 : {rb(), rb()};
      cmd(8'h06);
      wr(a, 32, 8, 1'b1);
      idle;
      rd({a[15:5], 5'h00}, 32);
    end
    rd(16'h0ffe, 4);
    for (i = 0; i < 4; i = i + 1) begin
      {block_protect_hi, block_protect_lo} <= i[1:0];
      cmd(8'h06);
      status({4'h0, i[1:0], 2'b10});
      wr(16'h0005, 1, 8, 1'b1);
      idle;
      cmd(8'h06);
      wr(16'h0fe5, 1, 8, 1'b1);
      idle;
      rd(16'h0005, 1);
      rd(16'h0fe5, 1);
    end
    wrap_up;
  end
  // Cut a hang short; the run needs well under half this span.
  initial begin
    repeat (100000) @(posedge clk_i);
    miscompares = miscompares + 1;
    wrap_up;
  end
endmodule // seaa_top_test
bind seaa_top seaa_top_monitor #(.TWC_CYCLES(TWC_CYCLES)) i_seaa_top_monitor (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n_i), .sck_i(sck_i),
  .si_i(si_i), .block_protect_lo(block_protect_lo),
  .block_protect_hi(block_protect_hi), .so_o(so_o), .so_oe_o(so_oe_o),
  .busy_o(busy_o), .wel_o(wel_o));
